// ==== hw/rx_status_pkg.sv ====
// constants for the receive descriptor status word builder
// assumes one 100 MHz clock and a word-aligned Avalon-MM register window
package rx_status_pkg;
   // ==========================================================
   // register window, byte offsets
   localparam logic [5:0] CTRL_OFS = 6'h00;
   localparam logic [5:0] STAT_OFS = 6'h04;
   localparam logic [5:0] LAST_OFS = 6'h08;
   localparam logic [5:0] COUNT_OFS = 6'h0C;
   localparam logic [5:0] LOG_OFS = 6'h20;
   localparam logic [31:0] CTRL_RST = 32'h00000001;
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_SERIAL_BIT = 1;
   localparam int unsigned WD_STAT_BIT = 9;
   localparam logic [1:0] RD_WAIT = 2'h2;
   localparam int unsigned LOG_AW = 3;
   // ==========================================================
   // status word layout
   localparam int unsigned OWN_BIT = 31;
   localparam int unsigned LEN_LSB = 16;
   localparam int unsigned LEN_MSB = 30;
   localparam int unsigned ES_BIT = 15;
   localparam int unsigned RF_BIT = 11;
   localparam int unsigned MF_BIT = 10;
   localparam int unsigned FS_BIT = 9;
   localparam int unsigned LS_BIT = 8;
   localparam int unsigned TL_BIT = 7;
   localparam int unsigned CS_BIT = 6;
   localparam int unsigned FT_BIT = 5;
   localparam int unsigned RW_BIT = 4;
   localparam int unsigned RE_BIT = 3;
   localparam int unsigned DB_BIT = 2;
   localparam int unsigned CE_BIT = 1;
   localparam int unsigned ZERO_BIT = 0;
   // ==========================================================
   // frame limits
   localparam logic [14:0] MAX_FRAME_LEN = 15'h05EE;
   localparam logic [15:0] TYPE_MIN = 16'h05DC;
   localparam logic [14:0] COLL_WINDOW = 15'h0040;
   localparam logic [14:0] HDR_LEN = 15'h000E;
   localparam logic [14:0] TYPE_HI_IDX = 15'h000C;
   localparam logic [14:0] TYPE_LO_IDX = 15'h000D;
   localparam logic [2:0] DRIB_NIBBLE = 3'h4;
   localparam logic [2:0] DRIB_SERIAL_MIN = 3'h3;
   typedef enum logic {RX_IDLE, RX_BUSY} rx_state_t;
endpackage

// ==== hw/rx_status_word.sv ====
// builds the status longword written into each receive descriptor
// assumes receive-path events synchronous to ref_clk, bytes before frame_end
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module rx_status_word
   import rx_status_pkg::*;
(
   input wire logic ref_clk, // 100 MHz clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [5:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire logic frame_start, // pulse, frame begins
   input wire logic frame_end, // pulse, frame complete
   input wire logic byte_valid, // pulse, one byte received
   input wire logic [7:0] byte_data, // received byte
   input wire logic [2:0] odd_bit_count, // extra bits, at frame_end
   input wire logic crc_ok, // checksum matched, at frame_end
   input wire logic phy_rx_err, // physical layer error
   input wire logic collision, // collision seen
   input wire logic overflow, // receive fifo overflow
   input wire logic watchdog_expired, // receive watchdog fired
   input wire logic desc_load, // pulse, new descriptor sizes valid
   input wire logic [10:0] buf1_size, // first buffer bytes
   input wire logic [10:0] buf2_size, // second buffer bytes
   output logic status_wr, // pulse, write status word
   output logic [31:0] rx_desc_status_word, // status word
   output logic watchdog_flag // device status watchdog bit
);
   import rx_status_pkg::*;

   function automatic logic [31:0] pack_word(input logic first, input logic last,
                                             input logic [31:0] body);
      logic [31:0] w;
      w = last ? body : 32'h00000000;
      w[FS_BIT] = first;
      w[LS_BIT] = last;
      w[OWN_BIT] = 1'b0;
      return w;
   endfunction

   // ==========================================================
   // frame tracking
   rx_state_t state_q, state_d;
   logic [14:0] byte_cnt_q;
   logic [11:0] desc_bytes_q;
   logic first_pend_q, desc_ok_q;
   logic mc_q, late_coll_q, early_coll_q, phy_err_q, ovf_q, wd_q;
   logic [15:0] type_q;
   logic [31:0] ctrl_q;
   logic busy, start_ok;
   logic [11:0] cap;
   logic emit_skip, emit_mid, emit_last, emit;
   logic phy_seen, ovf_seen, wd_seen, late_seen, runt, rf, tl, ft, drib_ok, db, ce;
   logic [31:0] last_body, word_d;

   assign busy = state_q == RX_BUSY;
   assign start_ok = frame_start && ctrl_q[CTRL_EN_BIT];
   assign cap = {1'b0, buf1_size} + {1'b0, buf2_size};
   assign emit_skip = busy && desc_ok_q && cap == 12'h000 && !frame_end;
   assign emit_mid = busy && byte_valid && cap != 12'h000 && desc_bytes_q == cap;
   assign emit_last = busy && frame_end;
   assign emit = emit_skip || emit_mid || emit_last;

   // events in the final cycle still count
   assign phy_seen = phy_err_q || phy_rx_err;
   assign ovf_seen = ovf_q || overflow;
   assign wd_seen = wd_q || watchdog_expired;
   assign late_seen = late_coll_q || (collision && byte_cnt_q >= COLL_WINDOW);
   assign runt = byte_cnt_q < COLL_WINDOW || early_coll_q ||
                 (collision && byte_cnt_q < COLL_WINDOW);
   assign rf = runt && !ovf_seen;
   assign tl = byte_cnt_q > MAX_FRAME_LEN;
   assign ft = byte_cnt_q >= HDR_LEN && type_q > TYPE_MIN;
   assign drib_ok = ctrl_q[CTRL_SERIAL_BIT] ? odd_bit_count >= DRIB_SERIAL_MIN
                                           : odd_bit_count == DRIB_NIBBLE;
   assign db = drib_ok && !late_seen && !runt;
   assign ce = !crc_ok || phy_seen;

   always_comb begin
      last_body = 32'h00000000;
      last_body[LEN_MSB:LEN_LSB] = wd_seen ? 15'h0000 : byte_cnt_q;
      last_body[ES_BIT] = ce || late_seen || tl || rf;
      last_body[RF_BIT] = rf;
      last_body[MF_BIT] = mc_q;
      last_body[TL_BIT] = tl;
      last_body[CS_BIT] = late_seen;
      last_body[FT_BIT] = ft;
      last_body[RW_BIT] = wd_seen;
      last_body[RE_BIT] = phy_seen;
      last_body[DB_BIT] = db;
      last_body[CE_BIT] = ce;
      last_body[ZERO_BIT] = ovf_seen;
   end

   // one word per emission, never assembled over several writes
   assign word_d = emit_last ? pack_word(first_pend_q, 1'b1, last_body) :
                   emit_mid ? pack_word(first_pend_q, 1'b0, 32'h00000000) :
                   pack_word(1'b0, 1'b0, 32'h00000000);

   always_comb begin
      state_d = state_q;
      if (start_ok) begin
         state_d = RX_BUSY;
      end else if (emit_last) begin
         state_d = RX_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= RX_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // byte counter never saturates or stops: oversize frames pass whole
   always_ff @(posedge ref_clk) begin
      if (!rst_n || start_ok) begin
         byte_cnt_q <= 15'h0000;
      end else if (busy && byte_valid) begin
         byte_cnt_q <= byte_cnt_q + 15'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || start_ok) begin
         desc_bytes_q <= 12'h000;
      end else if (emit_mid) begin
         desc_bytes_q <= 12'h001;
      end else if (busy && byte_valid) begin
         desc_bytes_q <= desc_bytes_q + 12'h001;
      end else if (emit_skip) begin
         desc_bytes_q <= 12'h000;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         desc_ok_q <= 1'b0;
      end else if (desc_load) begin
         desc_ok_q <= 1'b1;
      end else if (emit) begin
         desc_ok_q <= 1'b0;
      end
   end

   // skipped descriptors leave the first flag for the next one
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         first_pend_q <= 1'b0;
      end else if (start_ok) begin
         first_pend_q <= 1'b1;
      end else if (emit_mid || emit_last) begin
         first_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || start_ok) begin
         mc_q <= 1'b0;
         late_coll_q <= 1'b0;
         early_coll_q <= 1'b0;
         phy_err_q <= 1'b0;
         ovf_q <= 1'b0;
         wd_q <= 1'b0;
      end else if (busy) begin
         if (byte_valid && byte_cnt_q == 15'h0000) begin
            mc_q <= byte_data[0];
         end
         late_coll_q <= late_seen;
         early_coll_q <= early_coll_q || (collision && byte_cnt_q < COLL_WINDOW);
         phy_err_q <= phy_seen;
         ovf_q <= ovf_seen;
         wd_q <= wd_seen;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || start_ok) begin
         type_q <= 16'h0000;
      end else if (busy && byte_valid && byte_cnt_q == TYPE_HI_IDX) begin
         type_q[15:8] <= byte_data;
      end else if (busy && byte_valid && byte_cnt_q == TYPE_LO_IDX) begin
         type_q[7:0] <= byte_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         status_wr <= 1'b0;
         rx_desc_status_word <= 32'h00000000;
      end else begin
         status_wr <= emit;
         if (emit) begin
            rx_desc_status_word <= word_d;
         end
      end
   end

   // ==========================================================
   // register window
   logic [31:0] last_q, count_q, rd_mux, log_rdata;
   logic wd_stat_q;
   logic [LOG_AW-1:0] log_wptr_q;
   logic [1:0] rd_cnt_q;
   logic wr_ctrl, wr_stat, wd_clr, in_log;

   assign wr_ctrl = avs_write && avs_address == CTRL_OFS;
   assign wr_stat = avs_write && avs_address == STAT_OFS;
   assign wd_clr = wr_stat && avs_writedata[WD_STAT_BIT];
   assign in_log = avs_address >= LOG_OFS;
   assign avs_waitrequest = avs_read && rd_cnt_q != RD_WAIT;
   assign watchdog_flag = wd_stat_q;

   always_comb begin
      rd_mux = 32'h00000000;
      if (avs_address == CTRL_OFS) begin
         rd_mux = ctrl_q;
      end else if (avs_address == STAT_OFS) begin
         rd_mux[WD_STAT_BIT] = wd_stat_q;
      end else if (avs_address == LAST_OFS) begin
         rd_mux = last_q;
      end else if (avs_address == COUNT_OFS) begin
         rd_mux = count_q;
      end else if (in_log) begin
         rd_mux = log_rdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= {30'h00000000, avs_writedata[CTRL_SERIAL_BIT:CTRL_EN_BIT]};
      end
   end

   // a new watchdog event beats a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wd_stat_q <= 1'b0;
      end else if (emit_last && wd_seen) begin
         wd_stat_q <= 1'b1;
      end else if (wd_clr) begin
         wd_stat_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         last_q <= 32'h00000000;
         count_q <= 32'h00000000;
         log_wptr_q <= '0;
      end else if (emit_last) begin
         last_q <= word_d;
         count_q <= count_q + 32'h00000001;
         log_wptr_q <= log_wptr_q + 1'b1;
      end
   end

   // two wait cycles: memory read, then the registered answer
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !avs_read || rd_cnt_q == RD_WAIT) begin
         rd_cnt_q <= 2'h0;
      end else begin
         rd_cnt_q <= rd_cnt_q + 2'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && rd_cnt_q == 2'h1) begin
         avs_readdata <= rd_mux;
      end
   end

   status_log_mem #(.WIDTH(32), .AW(LOG_AW)) u_log (
      .ref_clk(ref_clk),
      .we(emit_last),
      .waddr(log_wptr_q),
      .wdata(word_d),
      .raddr(avs_address[LOG_AW+1:2]),
      .rdata_q(log_rdata)
   );

   // ==========================================================
   // checks
   own_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      status_wr |-> !rx_desc_status_word[OWN_BIT])
      else $error("ownership bit set in written status");

   summary_or_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      status_wr |-> rx_desc_status_word[ES_BIT] ==
         (rx_desc_status_word[CE_BIT] | rx_desc_status_word[CS_BIT] |
          rx_desc_status_word[TL_BIT] | rx_desc_status_word[RF_BIT]))
      else $error("error summary disagrees with flags");

   runt_overflow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      status_wr && rx_desc_status_word[ZERO_BIT] |-> !rx_desc_status_word[RF_BIT])
      else $error("runt flag set with overflow");

   mid_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      status_wr && !rx_desc_status_word[LS_BIT] |->
         rx_desc_status_word[OWN_BIT:LS_BIT+1] == {22'h000000, rx_desc_status_word[FS_BIT]}
         && rx_desc_status_word[LS_BIT-1:0] == 8'h00)
      else $error("flags in non-last descriptor");

   oversize_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      emit_last |=> rx_desc_status_word[TL_BIT] == ($past(byte_cnt_q) > MAX_FRAME_LEN))
      else $error("oversize flag wrong for length");

   wd_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      status_wr && rx_desc_status_word[RW_BIT] |->
         rx_desc_status_word[LEN_MSB:LEN_LSB] == 15'h0000)
      else $error("length reported with watchdog");

   wd_status_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      emit_last && wd_seen |=> wd_stat_q && status_wr && rx_desc_status_word[RW_BIT])
      else $error("watchdog status not raised");

   phy_crc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      emit_last && phy_seen |=> rx_desc_status_word[CE_BIT] && rx_desc_status_word[RE_BIT])
      else $error("phy error not reported");

   logic owed_first_q;
   always_ff @(posedge ref_clk) begin
      owed_first_q <= rst_n && (start_ok || (owed_first_q && !(emit_mid || emit_last)));
   end
   first_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (emit_mid || emit_last) && owed_first_q |=> status_wr && rx_desc_status_word[FS_BIT])
      else $error("first flag missing");

   read_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      avs_read && !$past(avs_read) |-> avs_waitrequest ##2 !avs_waitrequest)
      else $error("read answer not after two waits");
endmodule

// ==== hw/status_log_mem.sv ====
// small memory holding the last-descriptor status words of recent frames
// assumes one write port and one read port, both on ref_clk
`timescale 1ns/100ps
module status_log_mem #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned AW = 3
) (
   input wire logic ref_clk, // clock
   input wire logic we, // write strobe
   input wire logic [AW-1:0] waddr, // write address
   input wire logic [WIDTH-1:0] wdata, // write data
   input wire logic [AW-1:0] raddr, // read address
   output logic [WIDTH-1:0] rdata_q // registered read data
);
   logic [WIDTH-1:0] mem [2**AW];

   // no reset: contents are undefined until written
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end
endmodule

// ==== verif/host_desc_ring.sv ====
// host side model: collects every status word the block writes into descriptors
// assumes status_wr is a one-cycle pulse with the word valid beside it
`timescale 1ns/100ps
module host_desc_ring (
   input wire logic ref_clk, // clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic status_wr, // word write strobe
   input wire logic [rx_status_pkg::LEN_MSB:0] status_word, // word written
   output int words_q, // words written so far
   output int good_q // last-descriptor frames taken as good
);
   import rx_status_pkg::*;
   // ==========================================================
   // descriptor memory as the driver sees it
   logic [31:0] ring_q [0:31];
   wire logic last_w = status_word[LS_BIT];
   // odd trailing bits alone do not spoil a frame, only the error summary or a checksum error does
   wire logic good_w = last_w && !status_word[ES_BIT] && !status_word[CE_BIT];
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         words_q <= 0;
         good_q <= 0;
      end else if (status_wr) begin
         ring_q[words_q[4:0]] <= {1'h0, status_word};
         words_q <= words_q + 1;
         good_q <= good_q + int'(good_w);
      end
   end
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the receive status word builder
// assumes the package, the block and the host ring model are compiled first
`timescale 1ns/100ps
module tb;
   import rx_status_pkg::*;
   typedef struct {int n; logic [7:0] b0; logic [15:0] ty; logic [2:0] odd;
      logic [4:0] ev; int coll; logic [15:0] fl;} fcase_t;
   // ev holds {serial, watchdog, overflow, phy error, checksum good}
   localparam logic [15:0] ovf_m = 16'h0001, crc_m = 16'h0002, odd_m = 16'h0004;
   localparam logic [15:0] phy_m = 16'h0008, wd_m = 16'h0010, type_m = 16'h0020;
   localparam logic [15:0] coll_m = 16'h0040, long_m = 16'h0080, last_m = 16'h0100;
   localparam logic [15:0] first_m = 16'h0200, mc_m = 16'h0400, runt_m = 16'h0800;
   localparam logic [15:0] sum_m = 16'h8000;
   logic ref_clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rx_desc_status_word, rd;
   logic avs_waitrequest, status_wr, watchdog_flag;
   logic frame_start = 1'h0, frame_end = 1'h0, byte_valid = 1'h0, crc_ok = 1'h0;
   logic phy_rx_err = 1'h0, collision = 1'h0, overflow = 1'h0;
   logic watchdog_expired = 1'h0, desc_load = 1'h0;
   logic [7:0] byte_data = 8'h00;
   logic [2:0] odd_bit_count = 3'h0;
   logic [10:0] buf1_size = 11'h400, buf2_size = 11'h400;
   int fails = 0, samples_checked = 0, words_q, good_q, base = 0;
   fcase_t tc [12];
   fcase_t mc;

   always #5 ref_clk = ~ref_clk;

   rx_status_word i_rx_status_word (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .frame_start, .frame_end,
      .byte_valid, .byte_data, .odd_bit_count, .crc_ok, .phy_rx_err, .collision,
      .overflow, .watchdog_expired, .desc_load, .buf1_size, .buf2_size, .status_wr,
      .rx_desc_status_word, .watchdog_flag);
   host_desc_ring i_host_desc_ring (.ref_clk, .rst_n, .status_wr,
      .status_word(rx_desc_status_word[30:0]), .words_q, .good_q);

   // ==========================================================
   // checking and closing
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================================
   // register bus master, holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      logic done;
      done = 1'h0;
      @(posedge ref_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      for (int i = 0; i < 50 && !done; i++) begin
         @(posedge ref_clk);
         done = !avs_waitrequest;
         if (done) begin
            rd = avs_readdata;
         end
      end
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      if (!done) begin
         fails++;
         give_verdict();
      end
   endtask

   // ==========================================================
   // receive path driver; zd puts an empty descriptor ahead of the real one
   task automatic frame(input fcase_t c, input logic zd, input logic [10:0] sz);
      @(posedge ref_clk);
      frame_start <= 1'h1;
      @(posedge ref_clk);
      frame_start <= 1'h0;
      if (zd) begin
         desc_load <= 1'h1;
         {buf1_size, buf2_size} <= 22'h0;
         @(posedge ref_clk);
         // sizes stay zero one more cycle: the skip is judged after the load
         desc_load <= 1'h0;
         @(posedge ref_clk);
      end
      desc_load <= 1'h1;
      {buf1_size, buf2_size} <= {sz, sz};
      @(posedge ref_clk);
      desc_load <= 1'h0;
      for (int i = 0; i < c.n; i++) begin
         byte_valid <= 1'h1;
         byte_data <= i == 0 ? c.b0 : i == 12 ? c.ty[15:8] : i == 13 ? c.ty[7:0] : 8'(i);
         collision <= i == c.coll;
         phy_rx_err <= c.ev[1] && i == 1;
         overflow <= c.ev[2] && i == 1;
         watchdog_expired <= c.ev[3] && i == 1;
         @(posedge ref_clk);
      end
      byte_valid <= 1'h0;
      collision <= 1'h0;
      phy_rx_err <= 1'h0;
      overflow <= 1'h0;
      watchdog_expired <= 1'h0;
      frame_end <= 1'h1;
      odd_bit_count <= c.odd;
      crc_ok <= c.ev[0];
      @(posedge ref_clk);
      frame_end <= 1'h0;
   endtask

   // next word the host model received, waited for under a bound
   task automatic expect_word(input string what, input logic [31:0] exp);
      for (int i = 0; i < 30 && words_q <= base; i++) @(posedge ref_clk);
      if (words_q <= base) begin
         fails++;
         give_verdict();
      end
      chk(what, exp, i_host_desc_ring.ring_q[base[4:0]]);
      base++;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      tc[0] = '{64, 8'h01, 16'h0800, 3'h4, 5'h01, -1, mc_m | type_m | odd_m};
      tc[1] = '{64, 8'h02, 16'h05DC, 3'h3, 5'h03, -1, phy_m | crc_m | sum_m};
      tc[2] = '{64, 8'h00, 16'h05DD, 3'h0, 5'h00, -1, type_m | crc_m | sum_m};
      tc[3] = '{1519, 8'h00, 16'h0800, 3'h0, 5'h01, -1, type_m | long_m | sum_m};
      tc[4] = '{1518, 8'h00, 16'h0800, 3'h0, 5'h01, -1, type_m};
      tc[5] = '{10, 8'h00, 16'h0800, 3'h4, 5'h01, -1, runt_m | sum_m};
      tc[6] = '{100, 8'h00, 16'h0800, 3'h4, 5'h01, 70, type_m | coll_m | sum_m};
      tc[7] = '{100, 8'h00, 16'h0800, 3'h0, 5'h01, 10, type_m | runt_m | sum_m};
      tc[8] = '{20, 8'h00, 16'h0800, 3'h0, 5'h05, -1, type_m | ovf_m};
      tc[9] = '{64, 8'h00, 16'h0800, 3'h0, 5'h09, -1, type_m | wd_m};
      tc[10] = '{64, 8'h00, 16'h0800, 3'h3, 5'h11, -1, type_m | odd_m};
      tc[11] = '{64, 8'h00, 16'h0800, 3'h2, 5'h11, -1, type_m};
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'h1;
      bus(1'h0, CTRL_OFS, 32'h0);
      chk("ctrl reset", CTRL_RST, rd);
      bus(1'h0, 6'h10, 32'h0);
      chk("unmapped read", 32'h0, rd);
      $display("test registers done");
      for (int k = 0; k < 12; k++) begin
         bus(1'h1, CTRL_OFS, {30'h0, tc[k].ev[4], 1'h1});
         frame(tc[k], 1'h0, 11'h400);
         expect_word("frame word", {1'h0, tc[k].ev[3] ? 15'h0 : 15'(tc[k].n),
            tc[k].fl | first_m | last_m});
         $display("test frame case %0d done", k);
      end
      chk("watchdog flag", 32'h1, 32'(watchdog_flag));
      bus(1'h0, STAT_OFS, 32'h0);
      chk("watchdog status", 32'h1, 32'(rd[WD_STAT_BIT]));
      bus(1'h1, STAT_OFS, 32'h200);
      bus(1'h0, STAT_OFS, 32'h0);
      chk("watchdog cleared", 32'h0, 32'(rd[WD_STAT_BIT]));
      bus(1'h1, LAST_OFS, 32'hFFFFFFFF);
      bus(1'h0, LAST_OFS, 32'h0);
      chk("last word", 32'h00400320, rd);
      bus(1'h0, COUNT_OFS, 32'h0);
      chk("frame count", 32'h0000000C, rd);
      bus(1'h0, LOG_OFS + 6'h0C, 32'h0);
      chk("log entry", 32'h00400320, rd);
      $display("test status registers done");
      // capacity 64, so byte 65 closes the first descriptor early
      mc = '{100, 8'h00, 16'h0800, 3'h0, 5'h00, -1, 16'h0};
      frame(mc, 1'h0, 11'h020);
      expect_word("split first", {16'h0, first_m});
      expect_word("split last", {1'h0, 15'h0064, last_m | type_m | crc_m | sum_m});
      $display("test split frame done");
      mc.ev = 5'h01;
      mc.n = 64;
      frame(mc, 1'h1, 11'h400);
      expect_word("empty desc", 32'h0);
      expect_word("after empty", {1'h0, 15'h0040, first_m | last_m | type_m});
      $display("test empty descriptor done");
      chk("good frames", 32'h00000007, 32'(good_q));
      give_verdict();
   end
endmodule
